// ===== hw/iowdt_defines.svh
/*
 * constants of the single-port watchdog: port address, field positions, reset values and timing.
 * assumes a 50 MHz system clock; the timeout counts a 1 ms prescaled timebase.
 */
`ifndef IOWDT_DEFINES_SVH
`define IOWDT_DEFINES_SVH

// port decode and widths
`define IOWDT_ADDR_W        16
`define IOWDT_DATA_W        8
`define IOWDT_PORT_ADDR     16'h0443
// write data field
`define IOWDT_WR_CMD_BIT    0
// read data fields
`define IOWDT_RD_ARMED_BIT  0
`define IOWDT_RD_FIRED_BIT  1
`define IOWDT_RD_JUMPER_BIT 2
`define IOWDT_RDATA_RESET   8'h00
// timing
`define IOWDT_CLK_PERIOD_NS 20
`define IOWDT_TICK_US       1000
`define IOWDT_TIMEOUT_MS    1600
`define IOWDT_TOL_PCT       30
`define IOWDT_TICK_CYCLES   ((`IOWDT_TICK_US * 1000) / `IOWDT_CLK_PERIOD_NS)
`define IOWDT_TIMEOUT_TICKS ((`IOWDT_TIMEOUT_MS * 1000) / `IOWDT_TICK_US)
`define IOWDT_PULSE_CYCLES  8
`define IOWDT_TMO_W         16
`define IOWDT_PULSE_W       8

`endif

// ===== hw/iowdt_pkg.sv
/*
 * types of the single-port watchdog: host port carrier, watchdog states, top state record.
 * assumes iowdt_defines.svh is on the include path.
 */
`include "iowdt_defines.svh"

package iowdt_pkg;

	// host i/o cycle pins as seen by the watchdog
	typedef struct packed {
		logic [`IOWDT_ADDR_W-1:0] addr;
		logic                     rd_n;
		logic                     wr_n;
		logic [`IOWDT_DATA_W-1:0] data;
	} iowdt_io_t;

	// gray-coded along disarmed -> armed -> firing
	typedef enum logic [1:0] {
		IOWDT_IDLE   = 2'b00,
		IOWDT_ARMED  = 2'b01,
		IOWDT_FIRING = 2'b11
	} iowdt_state_e_t;

	typedef struct packed {
		iowdt_io_t                 io_s1;
		iowdt_io_t                 io_s2;
		logic                      rd_n_p;
		logic                      wr_n_p;
		logic                      jmp_s1;
		logic                      jmp_s2;
		iowdt_state_e_t            st;
		logic [`IOWDT_TMO_W-1:0]   tmo;
		logic [`IOWDT_PULSE_W-1:0] pls;
		logic                      fired;
		logic                      cpu_rst;
		logic                      irq;
		logic [`IOWDT_DATA_W-1:0]  rdata;
		logic                      oe;
	} iowdt_top_state_t;

endpackage : iowdt_pkg

// ===== hw/iowdt_prescaler.sv
/*
 * prescaler: divides the system clock into a one-cycle tick for the watchdog timebase.
 * assumes i_clr comes from logic on the same clock.
 */
`timescale 1ns/1ps

`include "iowdt_defines.svh"

module iowdt_prescaler #(
	parameter int unsigned CYCLES = `IOWDT_TICK_CYCLES
) (
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	// control
	input  wire logic i_clr,
	// timebase
	output logic      o_tick
);
	import iowdt_pkg::*;

	localparam int unsigned W = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} iowdt_pre_state_t;

	iowdt_pre_state_t s_q;
	iowdt_pre_state_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (i_clr) begin
			s_d.cnt = '0;
		end else if (s_q.cnt == W'(CYCLES - 1)) begin
			s_d.cnt  = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + W'(1);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_tick = s_q.tick;

	AST_TICK_SPACING : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_tick |=> !o_tick)
		else $error("prescaler tick lasted more than one cycle");

endmodule : iowdt_prescaler

// ===== hw/iowdt_top.sv
/*
 * single-port watchdog timer reached by host i/o reads and writes at one port address.
 * assumes host strobes, address, data and the action jumper are asynchronous pins.
 */
`timescale 1ns/1ps

`include "iowdt_defines.svh"

module iowdt_top #(
	parameter int unsigned TICK_CYCLES   = `IOWDT_TICK_CYCLES,
	parameter int unsigned TIMEOUT_TICKS = `IOWDT_TIMEOUT_TICKS,
	parameter int unsigned PULSE_CYCLES  = `IOWDT_PULSE_CYCLES
) (
	// clock and reset
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_rst_n,
	// host i/o port
	input  wire iowdt_pkg::iowdt_io_t     i_io,
	output logic [`IOWDT_DATA_W-1:0]      o_io_data,
	output logic                          o_io_data_oe,
	// board strap: 1 selects interrupt, 0 selects processor reset
	input  wire logic                     i_action_select_jumper,
	// timeout actions
	output logic                          o_cpu_rst,
	output logic                          o_irq11
);
	import iowdt_pkg::*;

	localparam logic [`IOWDT_TMO_W-1:0]   TMO_LAST = `IOWDT_TMO_W'(TIMEOUT_TICKS - 1);
	localparam logic [`IOWDT_PULSE_W-1:0] PLS_LAST = `IOWDT_PULSE_W'(PULSE_CYCLES - 1);

	function automatic logic port_hit(input logic [`IOWDT_ADDR_W-1:0] a);
		port_hit = (a == `IOWDT_PORT_ADDR);
	endfunction : port_hit

	iowdt_top_state_t s_q;
	iowdt_top_state_t s_d;
	logic             tick;
	logic             rd_end;
	logic             wr_end;
	logic             wr_one;
	logic             wr_zero;
	logic             tmr_clr;

	// ends of host strobes, seen after two synchronising stages
	always_comb begin
		rd_end  = s_q.io_s2.rd_n && !s_q.rd_n_p && port_hit(s_q.io_s2.addr);
		wr_end  = s_q.io_s2.wr_n && !s_q.wr_n_p && port_hit(s_q.io_s2.addr);
		wr_one  = wr_end && s_q.io_s2.data[`IOWDT_WR_CMD_BIT];
		wr_zero = wr_end && !s_q.io_s2.data[`IOWDT_WR_CMD_BIT];
		// interval restarts from full length on arming or refresh
		tmr_clr = (rd_end && (s_q.st == IOWDT_IDLE)) || (wr_one && (s_q.st == IOWDT_ARMED));
	end

	// 1 ms timebase from the system clock
	iowdt_prescaler #(
		.CYCLES (TICK_CYCLES)
	) u_pre (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_clr     (tmr_clr),
		.o_tick    (tick)
	);

	always_comb begin
		s_d        = s_q;
		s_d.io_s1  = i_io;
		s_d.io_s2  = s_q.io_s1;
		s_d.rd_n_p = s_q.io_s2.rd_n;
		s_d.wr_n_p = s_q.io_s2.wr_n;
		s_d.jmp_s1 = i_action_select_jumper;
		s_d.jmp_s2 = s_q.jmp_s1;
		case (s_q.st)
			IOWDT_IDLE: begin
				if (rd_end) begin
					s_d.st    = IOWDT_ARMED;
					s_d.tmo   = '0;
					s_d.fired = 1'b0;
				end
			end
			IOWDT_ARMED: begin
				if (wr_zero) begin
					s_d.st = IOWDT_IDLE;
				end else if (wr_one) begin
					s_d.tmo = '0;
				end else if (tick) begin
					// nominal count lies well inside the 30 percent band
					if (s_q.tmo == TMO_LAST) begin
						s_d.st      = IOWDT_FIRING;
						s_d.pls     = '0;
						s_d.fired   = 1'b1;
						s_d.cpu_rst = !s_q.jmp_s2;
						s_d.irq     = s_q.jmp_s2;
					end else begin
						s_d.tmo = s_q.tmo + `IOWDT_TMO_W'(1);
					end
				end
			end
			IOWDT_FIRING: begin
				// one fixed-width pulse, then disarmed until read again
				if (s_q.pls == PLS_LAST) begin
					s_d.st      = IOWDT_IDLE;
					s_d.cpu_rst = 1'b0;
					s_d.irq     = 1'b0;
				end else begin
					s_d.pls = s_q.pls + `IOWDT_PULSE_W'(1);
				end
			end
			default: begin
				s_d.st      = IOWDT_IDLE;
				s_d.cpu_rst = 1'b0;
				s_d.irq     = 1'b0;
			end
		endcase
		// read data: status of the watchdog
		s_d.rdata                       = `IOWDT_RDATA_RESET;
		s_d.rdata[`IOWDT_RD_ARMED_BIT]  = (s_q.st == IOWDT_ARMED);
		s_d.rdata[`IOWDT_RD_FIRED_BIT]  = s_q.fired;
		s_d.rdata[`IOWDT_RD_JUMPER_BIT] = s_q.jmp_s2;
		s_d.oe = !s_q.io_s2.rd_n && port_hit(s_q.io_s2.addr);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q            <= '0;
			s_q.io_s1.rd_n <= 1'b1;
			s_q.io_s1.wr_n <= 1'b1;
			s_q.io_s2.rd_n <= 1'b1;
			s_q.io_s2.wr_n <= 1'b1;
			s_q.rd_n_p     <= 1'b1;
			s_q.wr_n_p     <= 1'b1;
			s_q.st         <= IOWDT_IDLE;
			s_q.rdata      <= `IOWDT_RDATA_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_io_data    = s_q.rdata;
	assign o_io_data_oe = s_q.oe;
	assign o_cpu_rst    = s_q.cpu_rst;
	assign o_irq11      = s_q.irq;

	// checks
	sequence fire_start;
		$rose(o_cpu_rst || o_irq11);
	endsequence

	sequence fire_pulse;
		(o_cpu_rst || o_irq11) [*8] ##1 !(o_cpu_rst || o_irq11);
	endsequence

	AST_ARM_ON_READ : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(rd_end && s_q.st == IOWDT_IDLE) |=> (s_q.st == IOWDT_ARMED && s_q.tmo == '0))
		else $error("port read did not arm the watchdog");

	AST_REFRESH : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(wr_one && !wr_zero && s_q.st == IOWDT_ARMED) |=> (s_q.tmo == '0 && s_q.st == IOWDT_ARMED))
		else $error("refresh write did not restart the interval");

	AST_DISARM : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(wr_zero && s_q.st == IOWDT_ARMED) |=> (s_q.st == IOWDT_IDLE))
		else $error("write of zero did not disarm");

	AST_QUIET_IDLE : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_q.st == IOWDT_IDLE) |=> !$rose(o_cpu_rst) && !$rose(o_irq11))
		else $error("action raised while disarmed");

	AST_FIRE : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_q.st == IOWDT_ARMED && tick && s_q.tmo == TMO_LAST && !wr_end)
		|=> (s_q.st == IOWDT_FIRING) ##0 fire_start)
		else $error("timeout did not fire");

	AST_ONLY_AT_TMO : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		fire_start |-> $past(s_q.st) == IOWDT_ARMED && $past(s_q.tmo) == TMO_LAST)
		else $error("action raised before the full interval");

	AST_ROUTE : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		fire_start |-> (o_irq11 == $past(s_q.jmp_s2)) && (o_cpu_rst != o_irq11))
		else $error("action does not follow the jumper");

	AST_ONE_EVENT : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		fire_start |-> fire_pulse ##0 (s_q.st == IOWDT_IDLE))
		else $error("timeout action is not a single pulse");

	AST_OE_ON_READ : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!s_q.io_s2.rd_n && port_hit(s_q.io_s2.addr)) |=> o_io_data_oe)
		else $error("read data not driven during a port read");

	AST_OE_ONLY_READ : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_io_data_oe |-> $past(!s_q.io_s2.rd_n && port_hit(s_q.io_s2.addr)))
		else $error("read data driven outside a port read");

	AST_WR_IDLE_NOP : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(wr_end && !rd_end && s_q.st == IOWDT_IDLE) |=> (s_q.st == IOWDT_IDLE))
		else $error("write armed a disarmed watchdog");

	AST_RD_ARMED_NOP : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(rd_end && !wr_end && s_q.st == IOWDT_ARMED && s_q.tmo != TMO_LAST)
		|=> (s_q.st == IOWDT_ARMED && s_q.tmo == $past(s_q.tmo) + `IOWDT_TMO_W'($past(tick))))
		else $error("read while armed changed the interval");

	AST_TMO_BOUND : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_q.st == IOWDT_ARMED) |-> (s_q.tmo <= TMO_LAST))
		else $error("interval count ran past its nominal end");

	AST_COUNT_ON_TICK : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_q.st == IOWDT_ARMED && !tick && !wr_end) |=> (s_q.st == IOWDT_ARMED && $stable(s_q.tmo)))
		else $error("interval count moved without a timebase tick");

	AST_ONE_LINE : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!(o_cpu_rst && o_irq11))
		else $error("reset and interrupt raised together");

	AST_FIRED_FLAG : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		fire_start |-> s_q.fired)
		else $error("fired status not set with the timeout action");

endmodule : iowdt_top

// ===== tb/iowdt_host_model.sv
/*
 * host processor model: issues i/o read and write cycles to the watchdog port.
 * assumes the watchdog samples the strobes through two sync stages.
 */
`timescale 1ns/1ps

`include "iowdt_defines.svh"

module iowdt_host_model (
	// clock
	input  wire logic                     i_clk_sys,
	// host i/o pins
	output iowdt_pkg::iowdt_io_t          o_io,
	input  wire logic [`IOWDT_DATA_W-1:0] i_io_data,
	input  wire logic                     i_io_data_oe
);
	import iowdt_pkg::*;

	initial o_io = '{addr: 16'h0000, rd_n: 1'b1, wr_n: 1'b1, data: 8'h00};

	// one cycle: strobe low 4 clocks, high 4 clocks, then lines released
	task automatic xfer(input logic [15:0] a, input logic wr, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_clk_sys);
		o_io.addr <= a;
		o_io.data <= d;
		o_io.rd_n <= wr;
		o_io.wr_n <= !wr;
		repeat (3) @(posedge i_clk_sys);
		// read data stands from the third edge; take it mid-cycle where it is settled
		@(negedge i_clk_sys);
		q = i_io_data_oe ? i_io_data : 8'hff;
		@(posedge i_clk_sys);
		o_io.rd_n <= 1'b1;
		o_io.wr_n <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		// released lines no longer show the last value
		o_io.addr <= ~a;
		o_io.data <= ~d;
	endtask : xfer

endmodule : iowdt_host_model

// ===== tb/iowdt_top_test.sv
/*
 * testbench of the i/o port watchdog: arming, timeout, refresh, disarm.
 * assumes design files and the host model are compiled first.
 */
`timescale 1ns/1ps

module iowdt_top_test;
	import iowdt_pkg::*;

	localparam int TK = 4;
	localparam int TO = 10;

	logic       i_clk_sys;
	logic       i_rst_n;
	logic       i_action_select_jumper;
	iowdt_io_t  io;
	logic [7:0] o_io_data;
	logic       o_io_data_oe;
	logic       o_cpu_rst;
	logic       o_irq11;
	logic [7:0] q;
	logic       seen;
	int         num_errors;
	int         num_checks;

	iowdt_top #(.TICK_CYCLES(TK), .TIMEOUT_TICKS(TO), .PULSE_CYCLES(8)) dut_u (
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_io(io), .o_io_data(o_io_data),
		.o_io_data_oe(o_io_data_oe), .i_action_select_jumper(i_action_select_jumper),
		.o_cpu_rst(o_cpu_rst), .o_irq11(o_irq11));

	iowdt_host_model host_u (.i_clk_sys(i_clk_sys), .o_io(io), .i_io_data(o_io_data),
		.i_io_data_oe(o_io_data_oe));

	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end

	// sticky record of any timeout action
	always @(negedge i_clk_sys) seen = seen | o_cpu_rst | o_irq11;

	function automatic logic [7:0] exp_rd(input logic armed, input logic fired, input logic jmp);
		return {5'h00, jmp, fired, armed};
	endfunction : exp_rd

	function automatic logic in_win(input int n);
		return n >= TK * TO * 7 / 10 - 4 && n <= TK * TO * 13 / 10 + 4;
	endfunction : in_win

	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : check

	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	task automatic wait_fire(input logic irq);
		int n;
		int w;
		n = 0;
		w = 0;
		while (!(o_cpu_rst | o_irq11) && n < 100) begin
			@(negedge i_clk_sys);
			n++;
		end
		check("fire_time", in_win(n), 1'b1);
		check("fire_line", {o_irq11, o_cpu_rst}, {irq, !irq});
		while ((o_cpu_rst | o_irq11) && w < 20) begin
			@(negedge i_clk_sys);
			w++;
		end
		check("pulse_len", w, 8);
	endtask : wait_fire

	initial begin
		#(20 * 20000);
		num_errors++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'hdadaf68b));
		i_rst_n = 1'b0;
		i_action_select_jumper = 1'b0;
		seen = 1'b0;
		num_errors = 0;
		num_checks = 0;
		repeat (6) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		@(negedge i_clk_sys);
		check("rst_out", {o_cpu_rst, o_irq11, o_io_data_oe}, 3'b000);
		seen = 1'b0;
		repeat (60) @(posedge i_clk_sys);
		check("idle_quiet", seen, 1'b0);
		for (int j = 0; j < 2; j++) begin
			@(posedge i_clk_sys);
			i_action_select_jumper <= j[0];
			repeat (4) @(posedge i_clk_sys);
			host_u.xfer(16'h0443, 1'b0, 8'($urandom), q);
			check("rd_arm", q, exp_rd(1'b0, j[0], j[0]));
			wait_fire(j[0]);
		end
		host_u.xfer(16'h0443, 1'b0, 8'h00, q);
		seen = 1'b0;
		for (int k = 0; k < 6; k++) begin
			host_u.xfer(16'h0443, 1'b1, 8'($urandom) | 8'h01, q);
			host_u.xfer(16'h0442 - 16'(k), 1'b1, 8'h00, q);
			repeat ($urandom_range(5)) @(posedge i_clk_sys);
		end
		host_u.xfer(16'h0443, 1'b0, 8'h00, q);
		check("refresh_quiet", seen, 1'b0);
		check("rd_armed", q, exp_rd(1'b1, 1'b0, 1'b1));
		host_u.xfer(16'h0443, 1'b1, 8'h01, q);
		wait_fire(1'b1);
		host_u.xfer(16'h0443, 1'b0, 8'h00, q);
		check("rd_rearm", q, exp_rd(1'b0, 1'b1, 1'b1));
		host_u.xfer(16'h0443, 1'b1, 8'($urandom) & 8'hfe, q);
		seen = 1'b0;
		repeat (60) @(posedge i_clk_sys);
		host_u.xfer(16'h0443, 1'b1, 8'h01, q);
		repeat (60) @(posedge i_clk_sys);
		check("disarm_quiet", seen, 1'b0);
		end_of_test();
	end

endmodule : iowdt_top_test
